// File: rtl/gpd_log_mem.sv
`timescale 1ns/1ps
// ten-entry event memory, newest entry written at the head pointer
module gpd_log_mem (
   input  wire logic       sys_clk,
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic [3:0] rd_addr,
   output logic      [7:0] rd_data
);
   logic [7:0] mem [gpd_pkg::LOG_DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wr_en && wr_addr < 4'(gpd_pkg::LOG_DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rd_addr < 4'(gpd_pkg::LOG_DEPTH)) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= 8'h00;
      end
   end
endmodule : gpd_log_mem

// File: rtl/gpd_pkg.sv
package gpd_pkg;
   // ----------------------------------------------------------------------
   // command word layout
   // ----------------------------------------------------------------------
   localparam int CMD_BYTES      = 2;
   localparam int CMD_EN_BIT     = 9;
   localparam int CMD_GRIP_BIT   = 8;
   localparam int CMD_IDX_MSB    = 7;
   localparam int CMD_IDX_LSB    = 0;
   // ----------------------------------------------------------------------
   // status word layout
   // ----------------------------------------------------------------------
   localparam int STS_BYTES      = 4;
   localparam int STS_POS_LSB    = 16;
   localparam int STS_SW_LSB     = 12;
   localparam int STS_SVC_BIT    = 7;
   localparam int STS_TWARN_BIT  = 6;
   localparam int STS_TFAULT_BIT = 5;
   localparam int STS_ERR_BIT    = 4;
   localparam int STS_HOLD_BIT   = 3;
   localparam int STS_NOPART_BIT = 2;
   localparam int STS_REL_BIT    = 1;
   localparam int STS_IDLE_BIT   = 0;
   // ----------------------------------------------------------------------
   // temperatures in whole degrees celsius
   // ----------------------------------------------------------------------
   localparam logic signed [15:0] TEMP_WARN_LO   = 16'sh0000;
   localparam logic signed [15:0] TEMP_WARN_HI   = 16'sh0037;
   localparam logic signed [15:0] TEMP_HYST      = 16'sh0002;
   localparam logic signed [15:0] TEMP_FAULT_ON  = 16'sh0046;
   localparam logic signed [15:0] TEMP_FAULT_OFF = 16'sh0044;
   // ----------------------------------------------------------------------
   // counts, event log, timing
   // ----------------------------------------------------------------------
   localparam int        NUM_GRIPS      = 4;
   localparam int        NUM_SWITCHES   = 4;
   localparam int        LOG_DEPTH      = 10;
   localparam logic [15:0] LOG_INDEX_BASE = 16'h0100;
   localparam logic [7:0]  EVT_SERVICE    = 8'h01;
   localparam logic [7:0]  EVT_LUBE       = 8'h02;
   localparam logic [7:0]  EVT_ERROR      = 8'h03;
   localparam logic [7:0]  EVT_TFAULT     = 8'h04;
   localparam int        CLK_HZ         = 40_000_000;
   localparam int        FLASH_MS       = 250;
   localparam int        FLASH_CYCLES   = CLK_HZ / 1000 * FLASH_MS;
   localparam int        SETTLE_US      = 100;
   localparam int        SETTLE_CYCLES  = CLK_HZ / 1_000_000 * SETTLE_US;
   localparam logic [31:0] SERVICE_CYCLES = 32'h000f_4240;
   localparam logic [31:0] LUBE_CYCLES    = 32'h0000_c350;
   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      LAMP_OFF, LAMP_WHITE, LAMP_BLUE, LAMP_GREEN, LAMP_RED
   } gpd_lamp_type;
   typedef enum {
      GS_IDLE, GS_RELEASING, GS_RELEASED, GS_GRIPPING, GS_HOLDING, GS_NOPART
   } gpd_state_type;
endpackage : gpd_pkg

// File: rtl/gpd_process_data.sv
`timescale 1ns/1ps
module gpd_process_data (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // cyclic output image, one byte per strobe, msb first
   input  wire logic [7:0]         cmd_byte,
   input  wire logic               cmd_byte_valid,
   input  wire logic               cmd_frame_start,
   // cyclic input image
   input  wire logic               sts_frame_start,
   input  wire logic               sts_byte_ready,
   output logic      [7:0]         sts_byte,
   output logic                    sts_byte_valid,
   input  wire logic               link_running,
   // grip parameters, four grips packed, 1/100 mm
   input  wire logic [63:0]        release_limit,
   input  wire logic [63:0]        nopart_limit,
   input  wire logic [63:0]        switch_lo,
   input  wire logic [63:0]        switch_hi,
   // sensors
   input  wire logic [15:0]        jaw_pos,
   input  wire logic               jaw_still,
   input  wire logic [15:0]        temp_c,
   input  wire logic               hw_error,
   input  wire logic               cycle_done,
   input  wire logic               service_ack,
   // event log read port and event pulse with code
   input  wire logic [15:0]        log_index,
   output logic      [7:0]         log_data,
   output logic                    event_pulse,
   output logic      [7:0]         event_code,
   // actuators
   output logic                    valve_enable,
   output logic                    valve_vent,
   output logic                    move_close,
   output logic      [2:0]         lamp_colour,
   output logic                    lamp_on
);
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0]  s_link, s_still, s_err, s_done;
   logic [15:0] pos_m, pos_s, temp_m, temp_s;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_link  <= 2'h0;
         s_still <= 2'h0;
         s_err   <= 2'h0;
         s_done  <= 2'h0;
         pos_m   <= 16'h0000;
         pos_s   <= 16'h0000;
         temp_m  <= 16'h0000;
         temp_s  <= 16'h0000;
      end else begin
         s_link  <= {s_link[0], link_running};
         s_still <= {s_still[0], jaw_still};
         s_err   <= {s_err[0], hw_error};
         s_done  <= {s_done[0], cycle_done};
         pos_m   <= jaw_pos;
         pos_s   <= pos_m;
         temp_m  <= temp_c;
         temp_s  <= temp_m;
      end
   end

   logic signed [15:0] pos, temp;
   assign pos  = signed'(pos_s);
   assign temp = signed'(temp_s);

   // ----------------------------------------------------------------------
   // command word assembly
   // ----------------------------------------------------------------------
   logic [7:0]  cmd_hi;
   logic [15:0] cmd_word;
   logic        cmd_cnt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd_cnt  <= 1'b0;
         cmd_hi   <= 8'h00;
         cmd_word <= 16'h0000;
      end else if (cmd_frame_start) begin
         cmd_cnt <= 1'b0;
      end else if (cmd_byte_valid) begin
         // first byte is the high byte; a third byte starts a new pair
         if (!cmd_cnt) begin
            cmd_hi  <= cmd_byte;
            cmd_cnt <= 1'b1;
         end else begin
            cmd_word <= {6'h00, cmd_hi[1:0], cmd_byte};
            cmd_cnt  <= 1'b0;
         end
      end
   end

   logic       en, grip_req;
   logic [1:0] sel;
   assign en       = cmd_word[gpd_pkg::CMD_EN_BIT];
   assign grip_req = cmd_word[gpd_pkg::CMD_GRIP_BIT];
   // index above three wraps to the two low bits
   assign sel = cmd_word[gpd_pkg::CMD_IDX_LSB +: 2];

   function automatic logic signed [15:0] pick(input logic [63:0] v, input logic [1:0] i);
      pick = signed'(v[16*i +: 16]);
   endfunction : pick

   logic signed [15:0] rel_lim, np_lim;
   logic               closing_dir, in_window, past_np, at_rel;
   logic [1:0]         grip_sel;
   assign rel_lim = pick(release_limit, grip_sel);
   assign np_lim  = pick(nopart_limit, grip_sel);
   // gripping moves from the release limit towards the empty limit
   assign closing_dir = np_lim < rel_lim;
   assign in_window   = closing_dir ? (pos > np_lim && pos < rel_lim) : (pos < np_lim && pos > rel_lim);
   assign past_np     = closing_dir ? (pos <= np_lim) : (pos >= np_lim);
   assign at_rel      = closing_dir ? (pos >= rel_lim) : (pos <= rel_lim);

   // ----------------------------------------------------------------------
   // gripping state machine
   // ----------------------------------------------------------------------
   gpd_pkg::gpd_state_type state;
   logic [15:0] settle;
   logic        error;
   logic        twarn, tfault, svc;

   assign error = s_err[1] || tfault;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state    <= gpd_pkg::GS_IDLE;
         grip_sel <= 2'h0;
         settle   <= 16'h0000;
      end else if (!en || error) begin
         state  <= gpd_pkg::GS_IDLE;
         settle <= 16'h0000;
      end else begin
         case (state)
            gpd_pkg::GS_IDLE, gpd_pkg::GS_RELEASED, gpd_pkg::GS_HOLDING, gpd_pkg::GS_NOPART: begin
               if (grip_req && (state == gpd_pkg::GS_IDLE || state == gpd_pkg::GS_RELEASED)) begin
                  grip_sel <= sel;
                  state    <= gpd_pkg::GS_GRIPPING;
               end else if (!grip_req && state != gpd_pkg::GS_RELEASED) begin
                  state <= gpd_pkg::GS_RELEASING;
               end
               settle <= 16'h0000;
            end
            gpd_pkg::GS_GRIPPING: begin
               if (!grip_req) begin
                  state <= gpd_pkg::GS_RELEASING;
               end else if (past_np) begin
                  state <= gpd_pkg::GS_NOPART;
               end else if (in_window && s_still[1]) begin
                  if (settle == 16'(gpd_pkg::SETTLE_CYCLES - 1)) begin
                     state <= gpd_pkg::GS_HOLDING;
                  end
                  settle <= settle + 16'h0001;
               end else begin
                  settle <= 16'h0000;
               end
            end
            gpd_pkg::GS_RELEASING: begin
               if (grip_req) begin
                  state <= gpd_pkg::GS_GRIPPING;
               end else if (at_rel) begin
                  state <= gpd_pkg::GS_RELEASED;
               end
            end
            default: state <= gpd_pkg::GS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         valve_enable <= 1'b0;
         valve_vent   <= 1'b1;
         move_close   <= 1'b0;
      end else begin
         valve_enable <= en && !error && state != gpd_pkg::GS_IDLE;
         valve_vent   <= !en || error;
         move_close   <= closing_dir ? grip_req : !grip_req;
      end
   end

   // ----------------------------------------------------------------------
   // thermal monitoring and maintenance
   // ----------------------------------------------------------------------
   logic [31:0] cyc_cnt;
   logic [31:0] lube_cnt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         twarn  <= 1'b0;
         tfault <= 1'b0;
      end else begin
         if (temp < gpd_pkg::TEMP_WARN_LO || temp > gpd_pkg::TEMP_WARN_HI) begin
            twarn <= 1'b1;
         end else if (temp >= gpd_pkg::TEMP_WARN_LO + gpd_pkg::TEMP_HYST
                      && temp <= gpd_pkg::TEMP_WARN_HI - gpd_pkg::TEMP_HYST) begin
            twarn <= 1'b0;
         end
         if (temp > gpd_pkg::TEMP_FAULT_ON) begin
            tfault <= 1'b1;
         end else if (temp < gpd_pkg::TEMP_FAULT_OFF) begin
            tfault <= 1'b0;
         end
      end
   end

   logic svc_hit, lube_hit;
   assign svc_hit  = s_done[1] && cyc_cnt == gpd_pkg::SERVICE_CYCLES - 32'h1;
   assign lube_hit = s_done[1] && lube_cnt == gpd_pkg::LUBE_CYCLES - 32'h1;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cyc_cnt  <= 32'h0;
         lube_cnt <= 32'h0;
         svc      <= 1'b0;
      end else begin
         // the due flag wins over an acknowledge arriving together
         if (svc_hit) begin
            svc <= 1'b1;
         end else if (service_ack) begin
            svc <= 1'b0;
         end
         if (service_ack) begin
            cyc_cnt <= 32'h0;
         end else if (s_done[1] && !svc) begin
            cyc_cnt <= cyc_cnt + 32'h1;
         end
         if (lube_hit) begin
            lube_cnt <= 32'h0;
         end else if (s_done[1]) begin
            lube_cnt <= lube_cnt + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // events and log
   // ----------------------------------------------------------------------
   logic       err_d, tf_d;
   logic [3:0] head;
   logic [7:0] next_event;
   logic       next_fire;

   always_comb begin
      next_fire  = 1'b1;
      next_event = 8'h00;
      if (svc_hit) begin
         next_event = gpd_pkg::EVT_SERVICE;
      end else if (lube_hit) begin
         next_event = gpd_pkg::EVT_LUBE;
      end else if (s_err[1] && !err_d) begin
         next_event = gpd_pkg::EVT_ERROR;
      end else if (tfault && !tf_d) begin
         next_event = gpd_pkg::EVT_TFAULT;
      end else begin
         next_fire = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_d       <= 1'b0;
         tf_d        <= 1'b0;
         head        <= 4'h0;
         event_pulse <= 1'b0;
         event_code  <= 8'h00;
      end else begin
         err_d       <= s_err[1];
         tf_d        <= tfault;
         event_pulse <= next_fire;
         if (next_fire) begin
            event_code <= next_event;
            head <= (head == 4'(gpd_pkg::LOG_DEPTH - 1)) ? 4'h0 : head + 4'h1;
         end
      end
   end

   // entry 0 of the index range is the newest event
   logic [15:0] rel_idx;
   logic [4:0]  back;
   logic [3:0]  rd_addr;
   assign rel_idx = log_index - gpd_pkg::LOG_INDEX_BASE;
   assign back    = 5'(head) + 5'(gpd_pkg::LOG_DEPTH - 1) - 5'(rel_idx[3:0]);
   assign rd_addr = (rel_idx < 16'(gpd_pkg::LOG_DEPTH))
                    ? ((back >= 5'(gpd_pkg::LOG_DEPTH)) ? 4'(back - 5'(gpd_pkg::LOG_DEPTH)) : back[3:0])
                    : 4'hf;

   gpd_log_mem u_log (
      .sys_clk (sys_clk),
      .wr_en   (next_fire),
      .wr_addr (head),
      .wr_data (next_event),
      .rd_addr (rd_addr),
      .rd_data (log_data)
   );

   // ----------------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------------
   logic [3:0]  sw;
   logic [31:0] sts_word;

   always_comb begin
      for (int i = 0; i < gpd_pkg::NUM_SWITCHES; i++) begin
         sw[i] = pos >= pick(switch_lo, 2'(i)) && pos <= pick(switch_hi, 2'(i));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sts_word <= 32'h0000_0001;
      end else begin
         sts_word <= {pos, sw, 4'h0, svc, twarn, tfault, error,
                      state == gpd_pkg::GS_HOLDING,
                      state == gpd_pkg::GS_NOPART,
                      state == gpd_pkg::GS_RELEASED,
                      state == gpd_pkg::GS_IDLE};
      end
   end

   // snapshot taken at frame start, shifted out high byte first
   logic [31:0] sts_shift;
   logic [2:0]  sts_left;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sts_shift <= 32'h0;
         sts_left  <= 3'h0;
      end else if (sts_frame_start) begin
         sts_shift <= sts_word;
         sts_left  <= 3'(gpd_pkg::STS_BYTES);
      end else if (sts_byte_valid && sts_byte_ready) begin
         sts_shift <= {sts_shift[23:0], 8'h00};
         sts_left  <= sts_left - 3'h1;
      end
   end
   assign sts_byte       = sts_shift[31:24];
   assign sts_byte_valid = sts_left != 3'h0;

   // ----------------------------------------------------------------------
   // status lamp
   // ----------------------------------------------------------------------
   logic [23:0] flash_cnt;
   logic        flash;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flash_cnt   <= 24'h0;
         flash       <= 1'b0;
         lamp_colour <= gpd_pkg::LAMP_OFF;
         lamp_on     <= 1'b0;
      end else begin
         if (flash_cnt == 24'(gpd_pkg::FLASH_CYCLES - 1)) begin
            flash_cnt <= 24'h0;
            flash     <= !flash;
         end else begin
            flash_cnt <= flash_cnt + 24'h1;
         end
         lamp_on <= s_link[1] ? 1'b1 : flash;
         if (error) begin
            lamp_colour <= gpd_pkg::LAMP_RED;
         end else begin
            case (state)
               gpd_pkg::GS_IDLE:    lamp_colour <= gpd_pkg::LAMP_WHITE;
               gpd_pkg::GS_HOLDING: lamp_colour <= gpd_pkg::LAMP_GREEN;
               default:             lamp_colour <= gpd_pkg::LAMP_BLUE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   red_prio_a: assert property (@(posedge sys_clk) disable iff (rst) error |=> lamp_colour == gpd_pkg::LAMP_RED)
      else $error("red lamp missing while in error");
   vent_off_a: assert property (@(posedge sys_clk) disable iff (rst) !en |=> valve_vent && !valve_enable)
      else $error("valves not vented while disabled");
   idle_state_a: assert property (@(posedge sys_clk) disable iff (rst) !en ##1 !en |=> sts_word[0])
      else $error("idle bit not shown");
   fault_set_a: assert property (@(posedge sys_clk) disable iff (rst)
      temp > gpd_pkg::TEMP_FAULT_ON |=> tfault ##1 sts_word[5])
      else $error("thermal fault not reported");
   warn_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      twarn && temp == gpd_pkg::TEMP_WARN_HI |=> twarn)
      else $error("warning cleared inside hysteresis");
   svc_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
      service_ack && !svc_hit |=> !svc && cyc_cnt == 32'h0)
      else $error("service acknowledge ignored");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst) sts_word[11:8] == 4'h0)
      else $error("unused status bits not zero");
   hold_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(state == gpd_pkg::GS_HOLDING) |-> $past(state) == gpd_pkg::GS_GRIPPING)
      else $error("holding entered without a grip");
   steady_lamp_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_link[1] |=> lamp_on)
      else $error("lamp not steady while linked");
endmodule : gpd_process_data

// File: tb/gpd_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// cyclic master: command out, status in
// ----------------------------------------
module gpd_master_model (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  sts_byte,
   input  wire logic        sts_byte_valid,
   output logic      [7:0]  cmd_byte,
   output logic             cmd_byte_valid,
   output logic             cmd_frame_start,
   output logic             sts_frame_start,
   output logic             sts_byte_ready,
   output logic      [31:0] sts_word,
   output logic             sts_done
);
   initial begin
      cmd_byte = 8'h5a;
      cmd_byte_valid = 1'b0;
      cmd_frame_start = 1'b0;
      sts_frame_start = 1'b0;
      sts_byte_ready = 1'b0;
      sts_word = 32'h0000_0000;
      sts_done = 1'b0;
   end
   task send_cmd(input logic [15:0] w);
      @(posedge sys_clk) cmd_frame_start <= 1'b1;
      @(posedge sys_clk) cmd_frame_start <= 1'b0;
      cmd_byte_valid <= 1'b1;
      cmd_byte       <= w[15:8];
      @(posedge sys_clk) cmd_byte <= w[7:0];
      @(posedge sys_clk) cmd_byte_valid <= 1'b0;
      // idle byte lane shows the inverse so a stale sample is caught
      cmd_byte <= ~w[7:0];
   endtask : send_cmd
   task read_sts(input bit slow);
      @(posedge sys_clk) sts_frame_start <= 1'b1;
      @(posedge sys_clk) sts_frame_start <= 1'b0;
      sts_byte_ready <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         do @(posedge sys_clk); while (sts_byte_valid !== 1'b1 || sts_byte_ready !== 1'b1);
         sts_word <= {sts_word[23:0], sts_byte};
         if (slow && i < 3) begin
            sts_byte_ready <= 1'b0;
            @(posedge sys_clk) sts_byte_ready <= 1'b1;
         end
      end
      sts_byte_ready <= 1'b0;
      @(posedge sys_clk) sts_done <= 1'b1;
      @(posedge sys_clk) sts_done <= 1'b0;
   endtask : read_sts
endmodule : gpd_master_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic [15:0] cmd, pos, temp;
      logic        err;
      int          wt;
      logic [7:0]  lo, msk;
      logic [2:0]  lmp;
      logic [1:0]  mv;
   } gpd_step_type;
   logic        sys_clk, rst, cmd_byte_valid, cmd_frame_start, sts_frame_start, sts_byte_ready;
   logic        sts_byte_valid, link_running, jaw_still, hw_error, cycle_done, service_ack;
   logic        event_pulse, valve_enable, valve_vent, move_close, lamp_on, sts_done;
   logic [7:0]  cmd_byte, sts_byte, log_data, event_code;
   logic [63:0] release_limit, nopart_limit, switch_lo, switch_hi;
   logic [15:0] jaw_pos, temp_c, log_index, pos_r;
   logic [31:0] sts_word, m;
   logic [2:0]  lamp_colour;
   logic [31:0] exp_q[$], msk_q[$];
   int          err_count, compares, cyc, n;
   gpd_step_type st[12];
   gpd_process_data u_dut (.sys_clk(sys_clk), .rst(rst), .cmd_byte(cmd_byte), .cmd_byte_valid(cmd_byte_valid),
      .cmd_frame_start(cmd_frame_start), .sts_frame_start(sts_frame_start), .sts_byte_ready(sts_byte_ready),
      .sts_byte(sts_byte), .sts_byte_valid(sts_byte_valid), .link_running(link_running),
      .release_limit(release_limit), .nopart_limit(nopart_limit), .switch_lo(switch_lo), .switch_hi(switch_hi),
      .jaw_pos(jaw_pos), .jaw_still(jaw_still), .temp_c(temp_c), .hw_error(hw_error), .cycle_done(cycle_done),
      .service_ack(service_ack), .log_index(log_index), .log_data(log_data), .event_pulse(event_pulse),
      .event_code(event_code), .valve_enable(valve_enable), .valve_vent(valve_vent), .move_close(move_close),
      .lamp_colour(lamp_colour), .lamp_on(lamp_on));
   gpd_master_model u_master (.sys_clk(sys_clk), .sts_byte(sts_byte), .sts_byte_valid(sts_byte_valid),
      .cmd_byte(cmd_byte), .cmd_byte_valid(cmd_byte_valid), .cmd_frame_start(cmd_frame_start),
      .sts_frame_start(sts_frame_start), .sts_byte_ready(sts_byte_ready), .sts_word(sts_word), .sts_done(sts_done));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task print_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   function automatic logic [31:0] exp_sts(input logic [7:0] lo);
      logic [3:0] sw;
      for (int i = 0; i < 4; i++)
         sw[i] = $signed(jaw_pos) >= $signed(switch_lo[16*i+:16]) && $signed(jaw_pos) <= $signed(switch_hi[16*i+:16]);
      return {jaw_pos, sw, 4'h0, lo};
   endfunction : exp_sts
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         err_count++;
         print_verdict();
      end
   end
   // status watcher: oldest note against the word just read
   always @(posedge sys_clk) if (sts_done === 1'b1) begin
      m = msk_q.pop_front();
      chk("status", exp_q.pop_front(), sts_word & m);
   end
   initial begin
      rst = 1'b1;
      {link_running, jaw_still, hw_error, cycle_done, service_ack} = 5'b11000;
      release_limit = {4{16'sd1100}};
      nopart_limit = {16'sd1500, 16'sd100, 16'sd300, 16'sd100};
      switch_lo = {16'sd900, 16'sd600, 16'sd300, 16'sd0};
      switch_hi = {16'sd1200, 16'sd900, 16'sd600, 16'sd300};
      jaw_pos = 16'h0000;
      temp_c = 16'd25;
      log_index = 16'h0000;
      void'($urandom(44));
      pos_r = 16'(400 + $urandom % 600);
      st = '{'{16'h0000, pos_r, 16'd25, 1'b0, 20, 8'h01, 8'hff, 3'd1, 2'd2},
             '{16'h0200, 16'd1100, 16'd25, 1'b0, 100, 8'h02, 8'hff, 3'd2, 2'd0},
             '{16'hff03, 16'd1600, 16'd25, 1'b0, 100, 8'h04, 8'hff, 3'd2, 2'd0},
             '{16'h0200, 16'd1100, 16'd25, 1'b0, 100, 8'h02, 8'hff, 3'd2, 2'd1},
             '{16'h0304, pos_r, 16'd25, 1'b0, 4100, 8'h08, 8'hff, 3'd3, 2'd2},
             '{16'h0304, 16'h7fff, 16'd60, 1'b0, 20, 8'h40, 8'hf0, 3'd3, 2'd2},
             '{16'h0304, 16'h7fff, 16'd55, 1'b0, 20, 8'h40, 8'hf0, 3'd3, 2'd2},
             '{16'h0304, 16'h7fff, 16'd75, 1'b0, 20, 8'h70, 8'hf0, 3'd4, 2'd2},
             '{16'h0304, 16'h7fff, 16'd69, 1'b0, 20, 8'h70, 8'hf0, 3'd4, 2'd2},
             '{16'h0304, 16'h7fff, 16'd67, 1'b0, 20, 8'h40, 8'hf0, 3'd2, 2'd2},
             '{16'h0304, 16'h7fff, 16'd25, 1'b1, 20, 8'h10, 8'hf0, 3'd4, 2'd2},
             '{16'h0000, 16'h7fff, 16'd25, 1'b0, 20, 8'h01, 8'hff, 3'd1, 2'd2}};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (st[i]) begin
         u_master.send_cmd(st[i].cmd);
         if (st[i].pos != 16'h7fff)
            jaw_pos <= st[i].pos;
         temp_c <= st[i].temp;
         hw_error <= st[i].err;
         repeat (st[i].wt) @(posedge sys_clk);
         if (st[i].lmp != 3'd7)
            chk("lamp_colour", st[i].lmp, lamp_colour);
         chk("lamp_on", 1, lamp_on);
         if (st[i].mv != 2'd2)
            chk("move_close", st[i].mv[0], move_close);
         chk("valve_vent", 32'(!st[i].cmd[9] || st[i].lmp == 3'd4), valve_vent);
         chk("valve_enable", 32'(st[i].cmd[9] && st[i].lmp != 3'd4), valve_enable);
         msk_q.push_back({24'hffffff, st[i].msk});
         exp_q.push_back(exp_sts(st[i].lo) & {24'hffffff, st[i].msk});
         u_master.read_sts(i[0]);
      end
      // one lubrication interval of counted grip cycles
      cycle_done <= 1'b1;
      n = 0;
      while (event_pulse !== 1'b1 && n < 60000) begin
         @(posedge sys_clk);
         n++;
      end
      chk("event_code", gpd_pkg::EVT_LUBE, event_code);
      cycle_done <= 1'b0;
      service_ack <= 1'b1;
      log_index <= 16'h0100;
      @(posedge sys_clk);
      service_ack <= 1'b0;
      @(posedge sys_clk);
      chk("log_newest", gpd_pkg::EVT_LUBE, log_data);
      log_index <= 16'h0101;
      repeat (2) @(posedge sys_clk);
      chk("log_second", gpd_pkg::EVT_ERROR, log_data);
      log_index <= 16'h010a;
      repeat (2) @(posedge sys_clk);
      chk("log_outside", 0, log_data);
      // link lost: lamp falls into the dark half of its first flash period
      link_running <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("lamp_flash", 0, lamp_on);
      print_verdict();
   end
endmodule : tb_top
